// [core/ckp_clock_control.sv]
// Clock prescaler, freeze, real-time counter source and oscillator control
`timescale 1ns/1ps
`default_nettype none
`include "ckp_cfg.svh"

// Behaviour
// - First stage divides by one up to 512
// - First stage code may change while running
// - Second stage divides first stage output
// - Third stage divides second stage output
// - Two-bit code picks second/third stage ratios
// - Freeze blocks clock select and divider writes
// - Freeze stays set until reset
// - Freeze write needs protection key window
// - Three-bit code selects counter clock source
// - Counter source code output ungated, on bit beside it
// - Reset leaves only default oscillator enabled
// - Loop locked flag is status bit four
// - External stable flag is status bit three
// - Default oscillator stable flag is bit zero
// - Fast and slow stable flags bits 1,2
// - Clock select refused if source unstable
module ckp_clock_control (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready_reg,
  output logic [31:0]           prdata_reg,
  output logic                  pslverr_reg,
  // Oscillator control and raw stable levels from the analog sources
  input  wire ckp_pkg::ckp_osc_t oscStable,
  output ckp_pkg::ckp_osc_t     oscEnable_reg,
  output logic [2:0]            sysClkSel_reg,
  // Derived clock enables
  output logic                  quarterRateTick,
  output logic                  halfRateTick,
  output logic                  cpuTick,
  // Real-time counter source and freeze flag
  output logic [2:0]            rtcSourceCode_reg,
  output logic                  rtcSourceOn_reg,
  output logic                  frozen_reg
);

  localparam int WinCycles = `CKP_PROTECT_WINDOW_NS / `CKP_CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // First stage code is legal when zero or odd up to the largest ratio
  function automatic logic psaValid(input logic [4:0] code);
    return (code == 5'h00) || (code[0] && (code <= `CKP_PSA_MAX_CODE));
  endfunction

  // First stage code to power of two
  function automatic logic [3:0] psaShift(input logic [4:0] code);
    logic [5:0] t;
    t = {1'b0, code} + 6'h01;
    return (code == 5'h00) ? 4'h0 : t[4:1];
  endfunction

  // Stable flag of the source that a clock select code names
  function automatic logic sysSrcReady(input logic [2:0] code, input ckp_pkg::ckp_osc_t rdy);
    logic r;
    r = 1'b0;
    case (code)
      3'h0:    r = rdy.dfltOsc;
      3'h1:    r = rdy.fastOsc;
      3'h2:    r = rdy.slowOsc;
      3'h3:    r = rdy.ext;
      3'h4:    r = rdy.pll;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ckp_pkg::ckp_osc_t       oscMeta_reg;
  ckp_pkg::ckp_osc_t       oscSync_reg;
  ckp_pkg::ckp_osc_t       oscReady_reg;
  ckp_pkg::ckp_key_state_t keyState_reg;
  ckp_pkg::ckp_key_state_t keyState_next;
  logic [7:0]              win_reg;
  logic [7:0]              win_next;
  logic [4:0]              psaCode_reg;
  logic [1:0]              psbcCode_reg;
  logic [31:0]             rdNext;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire logic [5:0] regIdx    = paddr[7:2];
  wire logic       aligned   = (paddr[1:0] == 2'b00);
  wire logic       hitOscEn  = aligned && (regIdx == `CKP_IDX_OSC_ENABLE);
  wire logic       hitOscRdy = aligned && (regIdx == `CKP_IDX_OSC_READY);
  wire logic       hitFreeze = aligned && (regIdx == `CKP_IDX_FREEZE);
  wire logic       hitRtc    = aligned && (regIdx == `CKP_IDX_RTC_SELECT);
  wire logic       hitDiv    = aligned && (regIdx == `CKP_IDX_DIVIDER);
  wire logic       hitSys    = aligned && (regIdx == `CKP_IDX_SYSCLK_SEL);
  wire logic       hitKey    = aligned && (regIdx == `CKP_IDX_PROTECT_KEY);
  wire logic       mapped    = hitOscEn | hitOscRdy | hitFreeze | hitRtc | hitDiv | hitSys
                               | hitKey;
  wire logic       setupPh   = psel && !penable;
  wire logic       wrEdge    = psel && penable && pready_reg && pwrite;
  wire logic       keyOpen   = (keyState_reg == ckp_pkg::KEY_OPEN);
  wire logic       protWr    = wrEdge && keyOpen;

  // Write qualifiers
  wire logic [4:0] psaWr     = pwdata[`CKP_PSA_LSB +: 5];
  wire logic [2:0] rtcWr     = pwdata[`CKP_RTC_CODE_LSB +: 3];
  wire logic       freezeSet = protWr && hitFreeze && pwdata[`CKP_FREEZE_BIT];
  wire logic       divWrOk   = protWr && hitDiv && !frozen_reg && psaValid(psaWr);
  wire logic       sysWrOk   = protWr && hitSys && !frozen_reg
                               && sysSrcReady(pwdata[2:0], oscReady_reg);
  wire logic       rtcWrOk   = wrEdge && hitRtc && (rtcWr != 3'h3) && (rtcWr != 3'h4);
  wire logic       oscWr     = wrEdge && hitOscEn;

  // Read data mux
  always_comb begin
    rdNext = 32'h0000_0000;
    if (hitOscEn) begin
      rdNext[4:0] = oscEnable_reg;
    end else if (hitOscRdy) begin
      rdNext[4:0] = oscReady_reg;
    end else if (hitFreeze) begin
      rdNext[`CKP_FREEZE_BIT] = frozen_reg;
    end else if (hitRtc) begin
      rdNext[3:0] = {rtcSourceCode_reg, rtcSourceOn_reg};
    end else if (hitDiv) begin
      rdNext[6:0] = {psaCode_reg, psbcCode_reg};
    end else if (hitSys) begin
      rdNext[2:0] = sysClkSel_reg;
    end
  end

  // Zero-wait slave: data captured in setup, ready in the access cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setupPh;
      pslverr_reg <= setupPh && !mapped;
      if (setupPh) begin
        prdata_reg <= rdNext;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Protection window: key opens, one protected write or timeout closes
  // ----------------------------------------------------------------------
  always_comb begin
    keyState_next = keyState_reg;
    win_next      = win_reg;
    case (keyState_reg)
      ckp_pkg::KEY_CLOSED: begin
        if (wrEdge && hitKey && (pwdata[7:0] == `CKP_PROTECT_KEY)) begin
          keyState_next = ckp_pkg::KEY_OPEN;
          win_next      = 8'(WinCycles);
        end
      end
      ckp_pkg::KEY_OPEN: begin
        if (protWr && (hitFreeze || hitDiv || hitSys)) begin
          keyState_next = ckp_pkg::KEY_CLOSED;
          win_next      = 8'h00;
        end else if (win_reg <= 8'h01) begin
          keyState_next = ckp_pkg::KEY_CLOSED;
          win_next      = 8'h00;
        end else begin
          win_next = win_reg - 8'h01;
        end
      end
      default: begin
        keyState_next = ckp_pkg::KEY_CLOSED;
        win_next      = 8'h00;
      end
    endcase
  end

  // Window registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      keyState_reg <= ckp_pkg::KEY_CLOSED;
      win_reg      <= 8'h00;
    end else begin
      keyState_reg <= keyState_next;
      win_reg      <= win_next;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Freeze only sets; reset alone clears it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      frozen_reg <= 1'b0;
    end else if (freezeSet) begin
      frozen_reg <= 1'b1;
    end
  end

  // Divider codes and clock select, each write gated by freeze and key
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      psaCode_reg   <= `CKP_PSA_RST;
      psbcCode_reg  <= `CKP_PSBC_RST;
      sysClkSel_reg <= `CKP_SYSCLK_RST;
    end else begin
      if (divWrOk) begin
        psaCode_reg  <= psaWr;
        psbcCode_reg <= pwdata[`CKP_PSBC_LSB +: 2];
      end
      if (sysWrOk) begin
        sysClkSel_reg <= pwdata[2:0];
      end
    end
  end

  // Counter source select; reserved codes leave the old source
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rtcSourceCode_reg <= `CKP_RTC_CODE_RST;
      rtcSourceOn_reg   <= 1'b0;
    end else if (rtcWrOk) begin
      rtcSourceCode_reg <= rtcWr;
      rtcSourceOn_reg   <= pwdata[`CKP_RTC_ON_BIT];
    end
  end

  // Oscillator enables; only the default source runs after reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      oscEnable_reg <= `CKP_OSC_ENABLE_RST;
    end else if (oscWr) begin
      oscEnable_reg <= pwdata[4:0];
    end
  end

  // ----------------------------------------------------------------------
  // Stable levels: two-flop synchroniser, then gated by the enables
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      oscMeta_reg  <= 5'h00;
      oscSync_reg  <= 5'h00;
      oscReady_reg <= 5'h00;
    end else begin
      oscMeta_reg  <= oscStable;
      oscSync_reg  <= oscMeta_reg;
      oscReady_reg <= oscSync_reg & oscEnable_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler chain
  // ----------------------------------------------------------------------
  wire logic [3:0] shiftA = psaShift(psaCode_reg);
  wire logic [3:0] shiftB = (psbcCode_reg == 2'b10) ? 4'h2
                          : (psbcCode_reg == 2'b11) ? 4'h1 : 4'h0;
  wire logic [3:0] shiftC = psbcCode_reg[0] ? 4'h1 : 4'h0;

  // First stage runs on every system clock
  ckp_divider u_stage_a (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .inPulse      (1'b1),
    .shiftNext    (shiftA),
    .outPulse_reg (quarterRateTick)
  );

  // Second stage divides the quarter-rate ticks
  ckp_divider u_stage_b (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .inPulse      (quarterRateTick),
    .shiftNext    (shiftB),
    .outPulse_reg (halfRateTick)
  );

  // Third stage divides the half-rate ticks into processor ticks
  ckp_divider u_stage_c (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .inPulse      (halfRateTick),
    .shiftNext    (shiftC),
    .outPulse_reg (cpuTick)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_freeze_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
    frozen_reg |=> frozen_reg)
    else $error("freeze bit cleared without reset");

  a_frozen_divider: assert property (@(posedge sys_clk) disable iff (!rstn)
    (frozen_reg && wrEdge && (hitDiv || hitSys)) |=>
      ($stable(psaCode_reg) && $stable(psbcCode_reg) && $stable(sysClkSel_reg)))
    else $error("clock settings changed while frozen");

  a_freeze_key: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wrEdge && hitFreeze && !keyOpen && !frozen_reg) |=> !frozen_reg)
    else $error("freeze set without protection key");

  a_ready_enable: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> ((oscReady_reg & ~$past(oscEnable_reg)) == 5'h00))
    else $error("stable flag set for a disabled source");

  a_pll_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
    (oscEnable_reg.pll && oscStable.pll)[*3] ##1 (oscEnable_reg.pll && oscStable.pll)
      |=> oscReady_reg.pll)
    else $error("locked flag missing for an enabled stable loop");

  a_ext_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(oscEnable_reg.ext) |=> !oscReady_reg.ext[*2])
    else $error("external stable flag kept after disable");

  a_sysclk_refuse: assert property (@(posedge sys_clk) disable iff (!rstn)
    (protWr && hitSys && !sysSrcReady(pwdata[2:0], oscReady_reg)) |=> $stable(sysClkSel_reg))
    else $error("clock select taken for an unstable source");

  a_rtc_reserved: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wrEdge && hitRtc && ((rtcWr == 3'h3) || (rtcWr == 3'h4))) |=> $stable(rtcSourceCode_reg))
    else $error("reserved counter source code accepted");

  a_reset_default: assert property (@(posedge sys_clk)
    !rstn |=> (oscEnable_reg == 5'h01) && !frozen_reg && (sysClkSel_reg == 3'h0))
    else $error("wrong oscillator defaults after reset");

  c_freeze_set: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(frozen_reg));
  c_div_change: cover property (@(posedge sys_clk) disable iff (!rstn) divWrOk);
  c_sys_switch: cover property (@(posedge sys_clk) disable iff (!rstn) sysWrOk);
  c_key_timeout: cover property (@(posedge sys_clk) disable iff (!rstn)
    keyOpen ##1 (!keyOpen && !$past(protWr)));

endmodule // ckp_clock_control

`default_nettype wire

// [core/ckp_cfg.svh]
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef CKP_CFG_SVH
`define CKP_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define CKP_IDX_OSC_ENABLE   6'h00
`define CKP_IDX_OSC_READY    6'h01
`define CKP_IDX_FREEZE       6'h02
`define CKP_IDX_RTC_SELECT   6'h03
`define CKP_IDX_DIVIDER      6'h04
`define CKP_IDX_SYSCLK_SEL   6'h05
`define CKP_IDX_PROTECT_KEY  6'h06

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CKP_FREEZE_BIT       0
`define CKP_RTC_ON_BIT       0
`define CKP_RTC_CODE_LSB     1
`define CKP_PSA_LSB          2
`define CKP_PSBC_LSB         0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CKP_OSC_ENABLE_RST   5'h01
`define CKP_PSA_RST          5'h00
`define CKP_PSBC_RST         2'h0
`define CKP_SYSCLK_RST       3'h0
`define CKP_RTC_CODE_RST     3'h0

// ----------------------------------------------------------------------
// Protection key and timing
// ----------------------------------------------------------------------
`define CKP_PROTECT_KEY      8'hd8
`define CKP_CLK_PERIOD_NS    25
`define CKP_PROTECT_WINDOW_NS 200
`define CKP_PSA_MAX_CODE     5'h11

`endif

// [core/ckp_pkg.sv]
// Types shared by the clock control block
`default_nettype none

package ckp_pkg;

  // One bit per clock source, msb first as in the enable and ready registers
  typedef struct packed {
    logic pll;
    logic ext;
    logic slowOsc;
    logic fastOsc;
    logic dfltOsc;
  } ckp_osc_t;

  // Protected write window
  typedef enum logic {
    KEY_CLOSED,
    KEY_OPEN
  } ckp_key_state_t;

endpackage

`default_nettype wire

// [core/ckp_divider.sv]
// Power-of-two pulse divider stage with change only at a period boundary
`timescale 1ns/1ps
`default_nettype none

module ckp_divider #(
  parameter int SHIFT_W = 4,
  parameter int CNT_W   = 9
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // Input rate and requested ratio
  input  wire logic               inPulse,
  input  wire logic [SHIFT_W-1:0] shiftNext,
  // Divided rate
  output logic                    outPulse_reg
);

  logic [SHIFT_W-1:0] shift_reg;
  logic [CNT_W-1:0]   cnt_reg;
  wire  logic [CNT_W-1:0] limit;
  wire  logic             wrap;

  // Last count of the current period and the period end
  assign limit = ~({CNT_W{1'b1}} << shift_reg);
  assign wrap  = inPulse && (cnt_reg == limit);

  // New ratio only taken at a wrap, so no period is ever cut short
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      shift_reg    <= '0;
      cnt_reg      <= '0;
      outPulse_reg <= 1'b0;
    end else begin
      outPulse_reg <= wrap;
      if (wrap) begin
        cnt_reg   <= '0;
        shift_reg <= shiftNext;
      end else if (inPulse) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_out_on_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    wrap |=> outPulse_reg ##1 (outPulse_reg == $past(wrap)))
    else $error("divided pulse does not follow the period end");

  a_shift_at_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    !wrap |=> $stable(shift_reg))
    else $error("ratio changed inside a period");

endmodule // ckp_divider

`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
`include "ckp_cfg.svh"

module tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic              sys_clk, rstn, psel, penable, pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata_reg, rd;
  logic              pready_reg, pslverr_reg, er;
  ckp_pkg::ckp_osc_t oscStable, oscEnable_reg;
  logic [2:0]        sysClkSel_reg, rtcSourceCode_reg;
  logic              quarterRateTick, halfRateTick, cpuTick;
  logic              rtcSourceOn_reg, frozen_reg;
  int                errCount, samplesChecked;

  ckp_clock_control dut (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready_reg(pready_reg),
    .prdata_reg(prdata_reg), .pslverr_reg(pslverr_reg), .oscStable(oscStable),
    .oscEnable_reg(oscEnable_reg), .sysClkSel_reg(sysClkSel_reg),
    .quarterRateTick(quarterRateTick), .halfRateTick(halfRateTick),
    .cpuTick(cpuTick), .rtcSourceCode_reg(rtcSourceCode_reg),
    .rtcSourceOn_reg(rtcSourceOn_reg), .frozen_reg(frozen_reg)
  );

  // ----------------------------------------------------------------------
  // Clock, compare and closing
  // ----------------------------------------------------------------------
  // 40 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Bus and measurement helpers
  // ----------------------------------------------------------------------
  // One APB transfer; reads after an edge see the values held before it,
  // and one idle edge at the end lets the register update settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready_reg !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 0, 1);
    rd = prdata_reg;
    er = pslverr_reg;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // Open the timed protection window
  task automatic key;
    wr(8'h18, {24'h0, `CKP_PROTECT_KEY});
  endtask

  function automatic logic tk(input int s);
    return (s == 0) ? quarterRateTick : (s == 1) ? halfRateTick : cpuTick;
  endfunction

  // Cycles between two ticks, taken after two settling periods
  task automatic per(input int s, output int p);
    int k;
    for (k = 0; k < 3; k++) begin
      p = 0;
      do begin
        @(posedge sys_clk);
        p++;
      end while (tk(s) !== 1'b1 && p < 3000);
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk("oscEnable", oscEnable_reg, 32'h01);
    rdchk("oscCtl", 8'h00, 32'h01);
    rdchk("freeze", 8'h08, 32'h0);
    rdchk("divider", 8'h10, 32'h0);
    rdchk("key", 8'h18, 32'h0);
    rdchk("unmapped", 8'h1c, 32'h0);
    chk("slverr", er, 1);
    wr(8'h04, 32'h1f);
    rdchk("dfltReady", 8'h04, 32'h01);
  endtask

  task automatic t_ready;
    wr(8'h00, 32'h1f);
    repeat (5) @(posedge sys_clk);
    rdchk("readyNoExt", 8'h04, 32'h17);
    chk("oscEnableAll", oscEnable_reg, 32'h1f);
    oscStable <= 5'h1f;
    repeat (5) @(posedge sys_clk);
    rdchk("readyAll", 8'h04, 32'h1f);
    wr(8'h00, 32'h03);
    oscStable <= 5'h17;
    rdchk("readyOff", 8'h04, 32'h03);
  endtask

  task automatic t_select;
    key;
    wr(8'h14, 32'h1);
    chk("selFast", sysClkSel_reg, 32'h1);
    key;
    wr(8'h14, 32'h3);
    chk("selExtRefused", sysClkSel_reg, 32'h1);
    key;
    repeat (10) @(posedge sys_clk);
    wr(8'h14, 32'h0);
    chk("selLateKey", sysClkSel_reg, 32'h1);
    wr(8'h14, 32'h0);
    chk("selNoKey", sysClkSel_reg, 32'h1);
  endtask

  task automatic t_div;
    int i, j, p, b, c;
    for (i = 0; i < 10; i++) begin
      key;
      wr(8'h10, (i == 0) ? 32'h0 : ((2 * i - 1) << 2));
      per(0, p);
      chk("quarterPeriod", p, 1 << i);
    end
    key;
    wr(8'h10, 32'h15 << 2);
    rdchk("psaReserved", 8'h10, 32'h11 << 2);
    key;
    wr(8'h10, 32'h02 << 2);
    rdchk("psaEven", 8'h10, 32'h11 << 2);
    for (j = 0; j < 4; j++) begin
      b = (j == 2) ? 4 : (j == 3) ? 2 : 1;
      c = (j == 1 || j == 3) ? 2 : 1;
      key;
      wr(8'h10, 32'h4 | j);
      per(1, p);
      chk("halfPeriod", p, 2 * b);
      per(2, p);
      chk("cpuPeriod", p, 2 * b * c);
      rdchk("divReadback", 8'h10, 32'h4 | j);
    end
  endtask

  task automatic t_rtc;
    int c;
    logic [2:0] e;
    e = 3'h0;
    for (c = 0; c < 8; c++) begin
      // Reserved codes carry a cleared enable, which must not land either
      wr(8'h0c, (c << 1) | ((c == 3 || c == 4) ? 0 : 1));
      if (c != 3 && c != 4) e = 3'(c);
      chk("rtcCode", rtcSourceCode_reg, e);
      chk("rtcOn", rtcSourceOn_reg, 1);
    end
    wr(8'h0c, 32'hc);
    chk("rtcOff", rtcSourceOn_reg, 0);
    rdchk("rtcRead", 8'h0c, 32'hc);
  endtask

  task automatic t_freeze;
    wr(8'h08, 32'h1);
    chk("freezeNoKey", frozen_reg, 0);
    key;
    wr(8'h08, 32'h1);
    rdchk("freezeSet", 8'h08, 32'h1);
    key;
    wr(8'h10, 32'h07 << 2);
    rdchk("divFrozen", 8'h10, 32'h7);
    key;
    wr(8'h14, 32'h0);
    chk("selFrozen", sysClkSel_reg, 32'h1);
    key;
    wr(8'h08, 32'h0);
    chk("freezeStays", frozen_reg, 1);
    // Mid-run reset: only reset clears the freeze and restores the enables
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk("freezeReset", frozen_reg, 0);
    chk("oscEnableReset", oscEnable_reg, 32'h01);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    errCount = 0;
    samplesChecked = 0;
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; oscStable = 5'h17;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_ready;
    t_select;
    t_div;
    t_rtc;
    t_freeze;
    close_out;
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    errCount++;
    close_out;
  end
endmodule // tb

`default_nettype wire
